// ### iesopc_core.sv
// common-command status core: event latch, identity reply, completion tracking, pass-back address
// How it works
// - esr query returns the event byte as its weighted sum, bits 0 to 7
// - the event byte is cleared after the esr query reads it
// - an event bit sets when its condition rises
// - a set bit stays until esr query or clear-status
// - identity reply: quoted maker, model, ten-character serial, zero
// - sequential commands stall the command port; overlapped ones do not
// - internal no-pending-op flag is 1 only when no overlapped work is pending
// - after opc, bit 0 sets when the no-pending-op flag is 1
// - after opc query, +1 is queued once the flag is 1
// - clear, reset and device clears cancel armed opc; an opc query holds the command port until +1 is sent, so they cannot cancel it
// - opc completion can raise service request via bit 0 and bit 5 enables
// - pass-back accepts primary 0 to 30 and optional secondary 0 to 30
// - on finishing its bus job the device passes control to stored address
// - pass-back address survives reset commands; rst_n sets it back to primary 0, no secondary
// - event summary is the or of event bits anded with their enable bits
`timescale 1ns/1ns
module iesopc_core #(
  parameter int N_OVL = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command port
  input wire logic req_valid,
  input wire iesopc_pkg::iesopc_req_s req,
  output logic req_ready,
  input wire logic seq_busy,
  // event conditions and overlapped work
  input wire logic [7:0] event_cond,
  input wire logic [N_OVL-1:0] ovl_pending,
  input wire logic [7:0] esr_enable,
  input wire logic [8*iesopc_pkg::SERIAL_LEN-1:0] serial_num,
  // reply byte stream
  output iesopc_pkg::iesopc_out_s out_byte,
  output logic out_valid,
  input wire logic out_ready,
  // status and pass-control
  output logic [7:0] standard_event_latch,
  output logic esb_summary,
  output logic pcb_bad_addr,
  input wire logic bus_job_done,
  output logic pass_ctl_pulse,
  output logic [iesopc_pkg::ADDR_W-1:0] pass_pri,
  output logic pass_sec_valid,
  output logic [iesopc_pkg::ADDR_W-1:0] pass_sec
);
  // elaboration check: the pending mask needs at least one bit
  if (N_OVL < 1) begin : g_bad_n_ovl
    $error("N_OVL must be at least 1");
  end

  typedef enum logic [1:0] {
    IESOPC_IDLE = 2'b00,
    IESOPC_ESR = 2'b01,
    IESOPC_IDN = 2'b10,
    IESOPC_OPCQ = 2'b11
  } iesopc_state_e;

  iesopc_state_e state_reg;
  logic [7:0] cond_prev_reg;
  logic [4:0] idx_reg;
  logic [7:0] esr_snap_reg;
  logic [1:0] esr_digit_reg;
  logic opc_armed_reg;
  logic opcq_armed_reg;
  logic no_pending_op_flag;
  logic take;
  logic esr_clear;
  logic cancel;
  logic [7:0] ev_rise;
  logic [7:0] opc_set;
  logic [7:0] idn_char;
  logic [7:0] esr_char;
  logic [8*iesopc_pkg::IDN_LEN-1:0] idn_str;
  logic pcb_ok;

  assign take = req_valid && req_ready;
  assign no_pending_op_flag = ~|ovl_pending;
  assign cancel = take && (req.cmd == iesopc_pkg::IESOPC_CMD_CLS || req.cmd == iesopc_pkg::IESOPC_CMD_RST ||
                  req.cmd == iesopc_pkg::IESOPC_CMD_DCL || req.cmd == iesopc_pkg::IESOPC_CMD_SDC);
  assign esr_clear = (take && req.cmd == iesopc_pkg::IESOPC_CMD_ESRQ) ||
                     (take && req.cmd == iesopc_pkg::IESOPC_CMD_CLS);
  assign ev_rise = event_cond & ~cond_prev_reg;
  assign opc_set = {7'h00, opc_armed_reg && no_pending_op_flag && !cancel};
  assign idn_str = {iesopc_pkg::CH_QUOTE, iesopc_pkg::MAKER_STR, iesopc_pkg::CH_COMMA, iesopc_pkg::MODEL_STR,
                    iesopc_pkg::CH_COMMA, serial_num, iesopc_pkg::CH_COMMA, iesopc_pkg::CH_ZERO,
                    iesopc_pkg::CH_QUOTE};
  assign idn_char = idn_str[8*(iesopc_pkg::IDN_LEN-1-int'(idx_reg)) +: 8];
  assign pcb_ok = req.pri <= iesopc_pkg::ADDR_MAX && (!req.sec_valid || req.sec <= iesopc_pkg::ADDR_MAX);

  // decimal digits of the snapshot, most significant first, leading zeros dropped
  always_comb begin
    case (esr_digit_reg)
      2'h2: esr_char = iesopc_pkg::CH_ZERO + 8'(esr_snap_reg / 8'd100);
      2'h1: esr_char = iesopc_pkg::CH_ZERO + 8'((esr_snap_reg / 8'd10) % 8'd10);
      default: esr_char = iesopc_pkg::CH_ZERO + 8'(esr_snap_reg % 8'd10);
    endcase
  end

  // sequential work and pending replies hold the command port
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= !seq_busy && state_reg == IESOPC_IDLE && !take;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cond_prev_reg <= iesopc_pkg::ESR_RESET;
    end else begin
      cond_prev_reg <= event_cond;
    end
  end

  // event latch: sets win over read-clear and clear-status
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      standard_event_latch <= iesopc_pkg::ESR_RESET;
    end else if (esr_clear) begin
      standard_event_latch <= ev_rise | opc_set;
    end else begin
      standard_event_latch <= standard_event_latch | ev_rise | opc_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      esb_summary <= 1'b0;
    end else begin
      esb_summary <= |(standard_event_latch & esr_enable);
    end
  end

  // completion requests
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      opc_armed_reg <= 1'b0;
      opcq_armed_reg <= 1'b0;
    end else if (cancel) begin
      opc_armed_reg <= 1'b0;
      opcq_armed_reg <= 1'b0;
    end else begin
      if (take && req.cmd == iesopc_pkg::IESOPC_CMD_OPC) begin
        opc_armed_reg <= 1'b1;
      end else if (opc_armed_reg && no_pending_op_flag) begin
        opc_armed_reg <= 1'b0;
      end
      if (take && req.cmd == iesopc_pkg::IESOPC_CMD_OPCQ) begin
        opcq_armed_reg <= 1'b1;
      end else if (state_reg == IESOPC_OPCQ && out_valid && out_ready && out_byte.last) begin
        opcq_armed_reg <= 1'b0;
      end
    end
  end

  // reply sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= IESOPC_IDLE;
      idx_reg <= 5'h00;
      esr_snap_reg <= 8'h00;
      esr_digit_reg <= 2'h0;
      out_valid <= 1'b0;
      out_byte <= '0;
    end else begin
      case (state_reg)
        IESOPC_IDLE: begin
          out_valid <= 1'b0;
          idx_reg <= 5'h00;
          if (take && req.cmd == iesopc_pkg::IESOPC_CMD_ESRQ) begin
            state_reg <= IESOPC_ESR;
            esr_snap_reg <= standard_event_latch;
            esr_digit_reg <= standard_event_latch >= 8'd100 ? 2'h2 : (standard_event_latch >= 8'd10 ? 2'h1 : 2'h0);
          end else if (take && req.cmd == iesopc_pkg::IESOPC_CMD_IDNQ) begin
            state_reg <= IESOPC_IDN;
          end else if (take && req.cmd == iesopc_pkg::IESOPC_CMD_OPCQ) begin
            state_reg <= IESOPC_OPCQ;
          end
        end
        IESOPC_ESR: begin
          if (!out_valid || out_ready) begin
            if (out_valid && out_byte.last) begin
              out_valid <= 1'b0;
              state_reg <= IESOPC_IDLE;
            end else begin
              out_valid <= 1'b1;
              out_byte.data <= esr_char;
              out_byte.last <= esr_digit_reg == 2'h0;
              esr_digit_reg <= esr_digit_reg - 2'h1;
            end
          end
        end
        IESOPC_IDN: begin
          if (!out_valid || out_ready) begin
            if (out_valid && out_byte.last) begin
              out_valid <= 1'b0;
              state_reg <= IESOPC_IDLE;
            end else begin
              out_valid <= 1'b1;
              out_byte.data <= idn_char;
              out_byte.last <= int'(idx_reg) == iesopc_pkg::IDN_LEN - 1;
              idx_reg <= idx_reg + 5'h01;
            end
          end
        end
        IESOPC_OPCQ: begin
          if (!opcq_armed_reg || cancel) begin
            out_valid <= 1'b0;
            state_reg <= IESOPC_IDLE;
          end else if (!out_valid) begin
            if (no_pending_op_flag) begin
              out_valid <= 1'b1;
              out_byte.data <= iesopc_pkg::CH_PLUS;
              out_byte.last <= 1'b0;
            end
          end else if (out_ready) begin
            out_byte.data <= iesopc_pkg::CH_ONE;
            out_byte.last <= 1'b1;
            if (out_byte.last) begin
              out_valid <= 1'b0;
              state_reg <= IESOPC_IDLE;
            end
          end
        end
        default: state_reg <= IESOPC_IDLE;
      endcase
    end
  end

  // pass-back address: only rst_n and an accepted pass-back command change it, never the reset commands
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pass_pri <= iesopc_pkg::PCB_PRI_RESET;
      pass_sec <= iesopc_pkg::PCB_SEC_RESET;
      pass_sec_valid <= 1'b0;
      pcb_bad_addr <= 1'b0;
    end else begin
      pcb_bad_addr <= 1'b0;
      if (take && req.cmd == iesopc_pkg::IESOPC_CMD_PCB) begin
        if (pcb_ok) begin
          pass_pri <= req.pri;
          pass_sec <= req.sec;
          pass_sec_valid <= req.sec_valid;
        end else begin
          pcb_bad_addr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pass_ctl_pulse <= 1'b0;
    end else begin
      pass_ctl_pulse <= bus_job_done;
    end
  end
endmodule

// ### iesopc_core_assertions.sv
// checker for the common-command status core
`timescale 1ns/1ns
module iesopc_core_assertions #(
  parameter int N_OVL = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire iesopc_pkg::iesopc_req_s req,
  input wire logic req_ready,
  input wire iesopc_pkg::iesopc_out_s out_byte,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] event_cond,
  input wire logic [7:0] esr_enable,
  input wire logic [7:0] standard_event_latch,
  input wire logic esb_summary,
  input wire logic pcb_bad_addr,
  input wire logic bus_job_done,
  input wire logic pass_ctl_pulse,
  input wire logic [4:0] pass_pri
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] cond_q;
  always_ff @(posedge core_clk) begin
    cond_q <= event_cond;
  end
  wire [7:0] rise = event_cond & ~cond_q;
  wire take = req_valid && req_ready;
  wire pcb = take && req.cmd == iesopc_pkg::IESOPC_CMD_PCB;
  wire bad = req.pri > iesopc_pkg::ADDR_MAX || req.sec_valid && req.sec > iesopc_pkg::ADDR_MAX;
  wire clr = take && (req.cmd == iesopc_pkg::IESOPC_CMD_ESRQ || req.cmd == iesopc_pkg::IESOPC_CMD_CLS);
  a_evt_set: assert property (rise != 8'h00 |=> (standard_event_latch & $past(rise)) == $past(rise))
    else $error("event not latched");
  a_evt_hold: assert property (($past(standard_event_latch) & ~standard_event_latch) != 8'h00 |-> $past(clr))
    else $error("event bit lost");
  a_esb_sum: assert property ($stable(standard_event_latch) && $stable(esr_enable)
    |-> esb_summary == |(standard_event_latch & esr_enable))
    else $error("summary wrong");
  a_pcb_bad: assert property (pcb && bad |-> ##[1:2] pcb_bad_addr)
    else $error("bad address not flagged");
  a_pcb_store: assert property (pcb && !bad |=> pass_pri == $past(req.pri))
    else $error("address not stored");
  a_pass_back: assert property (bus_job_done |=> pass_ctl_pulse)
    else $error("no pass back");
  a_take_gap: assert property (take |=> !req_ready)
    else $error("ready after take");
  a_out_hold: assert property (out_valid && !out_ready && !take |=> out_valid && $stable(out_byte))
    else $error("reply byte dropped");
endmodule
bind iesopc_core iesopc_core_assertions #(.N_OVL(N_OVL)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .out_byte(out_byte), .out_valid(out_valid),
  .out_ready(out_ready), .event_cond(event_cond), .esr_enable(esr_enable),
  .standard_event_latch(standard_event_latch), .esb_summary(esb_summary), .pcb_bad_addr(pcb_bad_addr),
  .bus_job_done(bus_job_done), .pass_ctl_pulse(pass_ctl_pulse), .pass_pri(pass_pri));

// ### iesopc_ctl_model.sv
// controller model: collects reply bytes, can stall
`timescale 1ns/1ns
module iesopc_ctl_model (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic out_valid,
  input wire iesopc_pkg::iesopc_out_s out_byte,
  output logic out_ready
);
  logic [7:0] got[$];
  int n_last = 0;
  assign out_ready = !stall;
  always @(posedge core_clk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_byte.data);
      n_last = n_last + int'(out_byte.last);
    end
  end
endmodule

// ### iesopc_pkg.sv
// package: constants and carrier types for the common-command status block
package iesopc_pkg;
  localparam int ESR_W = 8;
  localparam logic [7:0] ESR_RESET = 8'h00;
  localparam int OPC_BIT = 0;
  localparam int STB_ESB_BIT = 5;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] PCB_PRI_RESET = 5'h00;
  localparam logic [4:0] PCB_SEC_RESET = 5'h00;
  localparam int SERIAL_LEN = 10;
  // idn reply length: quote + maker + ',' + model + ',' + serial + ",0" + quote
  localparam int MAKER_LEN = 6;
  localparam int MODEL_LEN = 4;
  localparam int IDN_LEN = 1 + MAKER_LEN + 1 + MODEL_LEN + 1 + SERIAL_LEN + 3;
  // identity strings: arbitrary neutral values
  localparam logic [8*MAKER_LEN-1:0] MAKER_STR = "ACMEIN";
  localparam logic [8*MODEL_LEN-1:0] MODEL_STR = "M100";
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_ONE = 8'h31;

  typedef enum logic [3:0] {
    IESOPC_CMD_NONE = 4'h0,
    IESOPC_CMD_ESRQ = 4'h1,
    IESOPC_CMD_IDNQ = 4'h2,
    IESOPC_CMD_OPC = 4'h3,
    IESOPC_CMD_OPCQ = 4'h4,
    IESOPC_CMD_CLS = 4'h5,
    IESOPC_CMD_RST = 4'h6,
    IESOPC_CMD_DCL = 4'h7,
    IESOPC_CMD_SDC = 4'h8,
    IESOPC_CMD_PCB = 4'h9
  } iesopc_cmd_e;

  typedef struct packed {
    iesopc_cmd_e cmd;
    logic [ADDR_W-1:0] pri;
    logic sec_valid;
    logic [ADDR_W-1:0] sec;
  } iesopc_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } iesopc_out_s;
endpackage

// ### tb_ieee488_status_opc_passctl.sv
// testbench for the common-command status core
`timescale 1ns/1ns
module tb_ieee488_status_opc_passctl;
  logic core_clk = 0;
  logic rst_n = 0;
  logic req_valid = 0;
  iesopc_pkg::iesopc_req_s req = '0;
  logic seq_busy = 0;
  logic [7:0] event_cond = 8'h00;
  logic [3:0] ovl_pending = 4'h0;
  logic [7:0] esr_enable = 8'h04;
  logic [79:0] serial_num = "SN01234567";
  logic bus_job_done = 0;
  logic stall = 0;
  logic req_ready, out_valid, out_ready, esb_summary, pcb_bad_addr, pass_ctl_pulse, pass_sv;
  iesopc_pkg::iesopc_out_s out_byte;
  logic [7:0] latch;
  logic [4:0] pass_pri, pass_sec;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int n_bad = 0;
  iesopc_core #(.N_OVL(4)) dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .seq_busy(seq_busy), .event_cond(event_cond), .ovl_pending(ovl_pending),
    .esr_enable(esr_enable), .serial_num(serial_num), .out_byte(out_byte), .out_valid(out_valid),
    .out_ready(out_ready), .standard_event_latch(latch), .esb_summary(esb_summary),
    .pcb_bad_addr(pcb_bad_addr), .bus_job_done(bus_job_done), .pass_ctl_pulse(pass_ctl_pulse),
    .pass_pri(pass_pri), .pass_sec_valid(pass_sv), .pass_sec(pass_sec));
  iesopc_ctl_model m (.core_clk(core_clk), .stall(stall), .out_valid(out_valid), .out_byte(out_byte),
    .out_ready(out_ready));
  always #2 core_clk = ~core_clk;
  task check(input logic [255:0] seen, input logic [255:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch %0t timeout", $time);
      finish_test;
    end
  end
  // counts refused pass-back addresses, one per pulse
  always @(posedge core_clk) begin
    if (pcb_bad_addr) begin
      n_bad++;
    end
  end
  task send(input iesopc_pkg::iesopc_cmd_e c, input logic [4:0] p = 5'h00, input logic v = 0,
    input logic [4:0] s = 5'h00);
    req_valid = 1;
    req = {c, p, v, s};
    @(posedge core_clk);
    while (!req_ready) @(posedge core_clk);
    @(negedge core_clk);
    req_valid = 0;
    @(negedge core_clk);
  endtask
  task reply(input logic [255:0] s, input int n);
    logic [255:0] g;
    g = '0;
    while (m.n_last == 0) @(negedge core_clk);
    foreach (m.got[k]) g = {g[247:0], m.got[k]};
    check(m.got.size(), n);
    check(g, s);
    m.got.delete();
    m.n_last = 0;
  endtask
  task test_esr;
    event_cond = 8'ha5;
    @(negedge core_clk);
    event_cond = 8'h00;
    repeat (2) @(negedge core_clk);
    check(latch, 8'ha5);
    check(esb_summary, 1'b1);
    stall = 1;
    event_cond = 8'h02;
    send(iesopc_pkg::IESOPC_CMD_ESRQ);
    event_cond = 8'h00;
    repeat (4) @(negedge core_clk);
    stall = 0;
    reply("165", 3);
    check(latch, 8'h02);
    check(esb_summary, 1'b0);
    send(iesopc_pkg::IESOPC_CMD_ESRQ);
    reply("2", 1);
    check(latch, 8'h00);
    event_cond = 8'h40;
    @(negedge core_clk);
    event_cond = 8'h00;
    send(iesopc_pkg::IESOPC_CMD_ESRQ);
    reply("64", 2);
    event_cond = 8'h81;
    @(negedge core_clk);
    event_cond = 8'h00;
    @(negedge core_clk);
    check(latch, 8'h81);
    send(iesopc_pkg::IESOPC_CMD_CLS);
    check(latch, 8'h00);
  endtask
  task test_opc;
    iesopc_pkg::iesopc_cmd_e cc[4] = '{iesopc_pkg::IESOPC_CMD_CLS, iesopc_pkg::IESOPC_CMD_RST,
      iesopc_pkg::IESOPC_CMD_DCL, iesopc_pkg::IESOPC_CMD_SDC};
    ovl_pending = 4'h3;
    send(iesopc_pkg::IESOPC_CMD_OPC);
    repeat (4) @(negedge core_clk);
    check(latch[0], 1'b0);
    ovl_pending = 4'h0;
    esr_enable = 8'h01;
    repeat (3) @(negedge core_clk);
    check(latch[0], 1'b1);
    check(esb_summary, 1'b1);
    ovl_pending = 4'h8;
    send(iesopc_pkg::IESOPC_CMD_OPCQ);
    repeat (6) @(negedge core_clk);
    check(m.got.size(), 0);
    ovl_pending = 4'h0;
    reply("+1", 2);
    foreach (cc[k]) begin
      ovl_pending = 4'h1;
      send(iesopc_pkg::IESOPC_CMD_OPC);
      send(cc[k]);
      ovl_pending = 4'h0;
      repeat (4) @(negedge core_clk);
      check(latch[0], 1'b0);
    end
  endtask
  task test_pcb;
    send(iesopc_pkg::IESOPC_CMD_PCB, 5'h1e, 1, 5'h11);
    check({pass_pri, pass_sv, pass_sec}, {5'h1e, 1'b1, 5'h11});
    check(n_bad, 0);
    send(iesopc_pkg::IESOPC_CMD_PCB, 5'h1f);
    send(iesopc_pkg::IESOPC_CMD_PCB, 5'h00, 1, 5'h1f);
    check(n_bad, 2);
    send(iesopc_pkg::IESOPC_CMD_RST);
    check({pass_pri, pass_sv, pass_sec}, {5'h1e, 1'b1, 5'h11});
    bus_job_done = 1;
    @(negedge core_clk);
    bus_job_done = 0;
    check(pass_ctl_pulse, 1'b1);
    seq_busy = 1;
    repeat (3) @(negedge core_clk);
    check(req_ready, 1'b0);
    seq_busy = 0;
    send(iesopc_pkg::IESOPC_CMD_IDNQ);
    reply({"\"", iesopc_pkg::MAKER_STR, ",", iesopc_pkg::MODEL_STR, ",", serial_num, ",0\""},
      iesopc_pkg::IDN_LEN);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    check(req_ready, 1'b0);
    rst_n = 1;
    repeat (3) @(negedge core_clk);
    test_esr;
    test_opc;
    test_pcb;
    finish_test;
  end
endmodule
